/* design/ion_gauge_interlock.sv */
// Purpose: setpoint, interlock, protection, remote and degas power logic
// Assumes: pressures and types come from logic on clk_sys; remoteIn are raw pins
// Notes: one lsb of pressure = 1e-11 torr
// Notes on behaviour
// [RQ1] process threshold accepted only from 5e-10 to 5e-3, else refused
// [RQ2] new process threshold sets hysteresis to 1.5 times it
// [RQ3] hand-set hysteresis must be at least 1.1 times the threshold
// [RQ4] interlock threshold lower bound depends on reference gauge type
// [RQ5] interlock threshold is 5e-3 torr after reset
// [RQ6] interlock threshold capped at 1e-2 (2e-2 with a diaphragm reference), or 9.5e-1 after range extension
// [RQ7] interlock mode enabled only with a valid reference channel selected
// [RQ8] auto mode: filament power follows reference pressure against threshold
// [RQ9] safe mode: reference turns power off, only manual turns it on
// [RQ10] off mode: reference ignored, power only by manual requests
// [RQ11] protection threshold always on, trips power off above it, default 5e-3
// [RQ12] power switching only for four gauge types, never diaphragm gauges
// [RQ13] cold ion gauge power request drives its anode high voltage enable
// [RQ14] degas on up to three small gauges, or one glass gauge
// [RQ15] remote falling edge turns power off, rising edge on, edges only
// [RQ16] six remote inputs; second of board may drive that board's degas
// [RQ17] remote inputs are held high by internal pull-up
// [RQ18] protection trip disables automatic control until a manual on
// [RQ19] process threshold direction fixed at below
// [RQ20] below output sets under threshold, clears above hysteresis
// [RQ21] remote inputs synchronised and debounced before edge detection
`timescale 1ns/1ps
module ion_gauge_interlock #(
  parameter int DEBOUNCE_CYCLES = ion_interlock_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire ion_interlock_pkg::gauge_type [ion_interlock_pkg::NCH-1:0] gaugeType,
  input wire ion_interlock_pkg::press_type [ion_interlock_pkg::NCH-1:0] pressure,
  input wire ion_interlock_pkg::press_type [ion_interlock_pkg::NCH-1:0] fullScale,
  input wire logic [ion_interlock_pkg::NBRD-1:0] glassGauge,
  input wire logic [ion_interlock_pkg::NBRD-1:0] remoteDegasSel,
  input wire logic [ion_interlock_pkg::NCH-1:0] remoteIn,
  input wire ion_interlock_pkg::cmd_type cmd,
  input wire logic rangeExtensionCommand,
  output logic [ion_interlock_pkg::NCH-1:0] remotePullupEn,
  output logic cmdAck,
  output logic cmdNak,
  output logic [ion_interlock_pkg::NCH-1:0] sensorPower,
  output logic [ion_interlock_pkg::NCH-1:0] anodeHvEn,
  output logic [ion_interlock_pkg::NBRD-1:0] degasOn,
  output logic [ion_interlock_pkg::NBRD-1:0] processSpOut,
  output logic [ion_interlock_pkg::NBRD-1:0] protTripped
);
  localparam int NCH = ion_interlock_pkg::NCH;
  localparam int NBRD = ion_interlock_pkg::NBRD;
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

  logic rangeExt_r;
  logic cmdAck_r;
  logic cmdNak_r;

  // power state
  logic [NCH-1:0] power_r;
  logic [NCH-1:0] power_nxt;
  logic [NBRD-1:0] degas_r;
  logic [NBRD-1:0] degas_nxt;

  // requests
  logic [NCH-1:0] remRise;
  logic [NCH-1:0] remFall;
  logic [NCH-1:0] manOn;
  logic [NCH-1:0] manOff;

  logic [NCH-1:0] chanOk;
  logic [NBRD-1:0] boardOk;

  // board state
  logic [NBRD-1:0] isFil;
  logic [NBRD-1:0] ilkAuto;
  logic [NBRD-1:0] ilkSafe;
  logic [NBRD-1:0] refBelow;
  logic [NBRD-1:0] autoOff;
  logic [NBRD-1:0] trip;

  logic [NBRD-1:0] dgOnReq;
  logic [NBRD-1:0] dgOffReq;
  logic [NBRD-1:0] dgGrant;

  wire logic opPwrOn = cmd.valid && cmd.op == ion_interlock_pkg::OP_POWER_ON;
  wire logic opPwrOff = cmd.valid && cmd.op == ion_interlock_pkg::OP_POWER_OFF;
  wire logic opDgOn = cmd.valid && cmd.op == ion_interlock_pkg::OP_DEGAS_ON;
  wire logic opDgOff = cmd.valid && cmd.op == ion_interlock_pkg::OP_DEGAS_OFF;
  wire logic cmdOk = (|boardOk) || (|chanOk);

  assign remotePullupEn = '1; // RQ17
  assign cmdAck = cmdAck_r;
  assign cmdNak = cmdNak_r;
  assign sensorPower = power_r;
  assign degasOn = degas_r;

  ////////////////////////////////////////////////////////////////////////////
  // per channel: remote input conditioning and power switching
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic sync1_r;
      logic sync2_r;
      logic level_r;
      logic rise_r;
      logic fall_r;
      logic [CW-1:0] cnt_r;

      wire logic settled = cnt_r == CW'(DEBOUNCE_CYCLES - 1);
      wire logic pwrCapable = gaugeType[i] == ion_interlock_pkg::THERMAL_CONDUCTIVITY_GAUGE ||
                              gaugeType[i] == ion_interlock_pkg::CONVECTION_GAUGE ||
                              gaugeType[i] == ion_interlock_pkg::COLD_ION_GAUGE ||
                              gaugeType[i] == ion_interlock_pkg::FILAMENT_ION_GAUGE; // RQ12
      wire logic hitChan = cmd.chan == 3'(i);
      // the second channel of a board may be routed to degas instead
      wire logic toDegas = (i % 2 == 1) && remoteDegasSel[i/2]; // RQ16

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1_r <= 1'b1;
          sync2_r <= 1'b1;
          level_r <= 1'b1;
          rise_r <= 1'b0;
          fall_r <= 1'b0;
          cnt_r <= '0;
        end else if (clkEn) begin
          sync1_r <= remoteIn[i]; // RQ21
          sync2_r <= sync1_r;
          rise_r <= settled && sync2_r && !level_r; // RQ15
          fall_r <= settled && !sync2_r && level_r; // RQ15
          if (sync2_r == level_r) begin
            cnt_r <= '0;
          end else if (settled) begin
            level_r <= sync2_r; // RQ21
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + CW'(1);
          end
        end
      end

      assign remRise[i] = rise_r;
      assign remFall[i] = fall_r;
      assign manOn[i] = (opPwrOn && hitChan) || (rise_r && !toDegas);
      assign manOff[i] = (opPwrOff && hitChan) || (fall_r && !toDegas);
      assign chanOk[i] = (opPwrOn || opPwrOff) && hitChan && pwrCapable;
      assign anodeHvEn[i] = power_r[i] && gaugeType[i] == ion_interlock_pkg::COLD_ION_GAUGE; // RQ13

      always_comb begin
        power_nxt[i] = power_r[i];
        if (manOff[i]) begin
          power_nxt[i] = 1'b0;
        end else if (manOn[i]) begin
          power_nxt[i] = 1'b1;
        end
        if (i % 2 == 0 && isFil[i/2]) begin
          if (ilkAuto[i/2] && !autoOff[i/2]) begin
            power_nxt[i] = refBelow[i/2]; // RQ8
          end else if (ilkSafe[i/2] && !refBelow[i/2]) begin
            power_nxt[i] = 1'b0; // RQ9
          end
          if (trip[i/2]) begin
            power_nxt[i] = 1'b0; // RQ11
          end
        end
        if (!pwrCapable) begin
          power_nxt[i] = 1'b0; // RQ12
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // per board: thresholds, interlock and protection of the filament gauge
  genvar b;
  generate
    for (b = 0; b < NBRD; b++) begin : g_brd
      localparam int FC = 2 * b;
      ion_interlock_pkg::press_type procSp_r;
      ion_interlock_pkg::press_type hyst_r;
      ion_interlock_pkg::press_type ctrlSp_r;
      ion_interlock_pkg::press_type protSp_r;
      ion_interlock_pkg::ctrl_mode_type mode_r;
      logic [2:0] refSel_r;
      logic autoOff_r;
      logic spOut_r;

      wire ion_interlock_pkg::press_type v = cmd.value;
      wire logic hit = cmd.valid && cmd.chan[2:1] == 2'(b);
      wire logic fil = gaugeType[FC] == ion_interlock_pkg::FILAMENT_ION_GAUGE;

      wire logic [2:0] refIdx = (refSel_r < 3'(NCH)) ? refSel_r : 3'h0;
      wire logic [2:0] newIdx = (v[2:0] < 3'(NCH)) ? v[2:0] : 3'h0;
      wire ion_interlock_pkg::gauge_type refT = gaugeType[refIdx];
      wire ion_interlock_pkg::gauge_type newT = gaugeType[newIdx];
      wire logic refOk = refSel_r < 3'(NCH) && refSel_r != 3'(FC) &&
                         (refT == ion_interlock_pkg::THERMAL_CONDUCTIVITY_GAUGE ||
                          refT == ion_interlock_pkg::CONVECTION_GAUGE ||
                          refT == ion_interlock_pkg::DIAPHRAGM_GAUGE);
      wire logic newRefOk = v < ion_interlock_pkg::press_type'(NCH) && v[2:0] != 3'(FC) &&
                            (newT == ion_interlock_pkg::THERMAL_CONDUCTIVITY_GAUGE ||
                             newT == ion_interlock_pkg::CONVECTION_GAUGE ||
                             newT == ion_interlock_pkg::DIAPHRAGM_GAUGE);
      wire logic [ion_interlock_pkg::PW+3:0] hystScaled = {4'h0, v} * ion_interlock_pkg::HYST_MIN_DEN;
      wire logic [ion_interlock_pkg::PW+3:0] minScaled = {4'h0, procSp_r} * ion_interlock_pkg::HYST_MIN_NUM;
      wire logic [ion_interlock_pkg::PW+8:0] fsScaled = {9'h0, v} * ion_interlock_pkg::FS_DIV;
      wire ion_interlock_pkg::press_type ctrlMax = rangeExt_r ? ion_interlock_pkg::P_9P5E_1 :
        (refT == ion_interlock_pkg::DIAPHRAGM_GAUGE ? ion_interlock_pkg::P_2E_2 : ion_interlock_pkg::P_1E_2);
      wire logic ctrlMinOk = (refT == ion_interlock_pkg::THERMAL_CONDUCTIVITY_GAUGE) ?
                               v >= ion_interlock_pkg::P_5E_4 :
                             (refT == ion_interlock_pkg::CONVECTION_GAUGE) ? v >= ion_interlock_pkg::P_2E_3 :
                             fsScaled >= {9'h0, fullScale[refIdx]};
      wire ion_interlock_pkg::ctrl_mode_type newMode = ion_interlock_pkg::ctrl_mode_type'(v[1:0]);
      wire logic okProc = v >= ion_interlock_pkg::P_5E_10 && v <= ion_interlock_pkg::P_5E_3; // RQ1
      wire logic okHyst = hystScaled >= minScaled; // RQ3
      wire logic okCtrl = refOk && ctrlMinOk && v <= ctrlMax; // RQ4 RQ6
      wire logic okMode = (newMode == ion_interlock_pkg::CTRL_OFF) ||
                          (refOk && (newMode == ion_interlock_pkg::CTRL_SAFE ||
                                     newMode == ion_interlock_pkg::CTRL_AUTO)); // RQ7
      wire logic okProt = v >= ion_interlock_pkg::P_1E_5 && v <= ion_interlock_pkg::P_1E_2; // RQ11

      wire logic wProc = hit && fil && cmd.op == ion_interlock_pkg::OP_PROCESS_THRESHOLD && okProc;
      wire logic wHyst = hit && fil && cmd.op == ion_interlock_pkg::OP_HYSTERESIS && okHyst;
      wire logic wCtrl = hit && fil && cmd.op == ion_interlock_pkg::OP_INTERLOCK_THRESHOLD && okCtrl;
      wire logic wRef = hit && fil && cmd.op == ion_interlock_pkg::OP_REFERENCE_CHANNEL_SELECT && newRefOk;
      wire logic wMode = hit && fil && cmd.op == ion_interlock_pkg::OP_MODE && okMode;
      wire logic wProt = hit && fil && cmd.op == ion_interlock_pkg::OP_PROTECT && okProt;

      wire logic tripNow = fil && power_r[FC] && pressure[FC] > protSp_r; // RQ11
      wire logic active = fil && refOk; // RQ10

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          procSp_r <= ion_interlock_pkg::P_1E_6;
          hyst_r <= ion_interlock_pkg::P_1P5E_6;
          ctrlSp_r <= ion_interlock_pkg::P_5E_3; // RQ5
          protSp_r <= ion_interlock_pkg::P_5E_3;
          mode_r <= ion_interlock_pkg::CTRL_OFF;
          refSel_r <= ion_interlock_pkg::REF_NONE;
          autoOff_r <= 1'b0;
          spOut_r <= 1'b0;
        end else if (clkEn) begin
          if (wProc) begin
            procSp_r <= v;
            hyst_r <= v + (v >> 1); // RQ2
          end else if (wHyst) begin
            hyst_r <= v; // RQ3
          end
          if (wCtrl) begin
            ctrlSp_r <= v;
          end
          if (wProt) begin
            protSp_r <= v;
          end
          if (wMode) begin
            mode_r <= newMode;
          end
          if (wRef) begin
            refSel_r <= v[2:0];
          end
          // trip wins over a manual on in the same cycle
          if (tripNow) begin
            autoOff_r <= 1'b1; // RQ18
          end else if (manOn[FC]) begin
            autoOff_r <= 1'b0; // RQ18
          end
          // below only: set under threshold, clear above hysteresis
          if (pressure[FC] < procSp_r) begin
            spOut_r <= 1'b1; // RQ19 RQ20
          end else if (pressure[FC] > hyst_r) begin
            spOut_r <= 1'b0; // RQ20
          end
        end
      end

      assign isFil[b] = fil;
      assign ilkAuto[b] = active && mode_r == ion_interlock_pkg::CTRL_AUTO; // RQ8
      assign ilkSafe[b] = active && mode_r == ion_interlock_pkg::CTRL_SAFE; // RQ9
      assign refBelow[b] = pressure[refIdx] < ctrlSp_r;
      assign autoOff[b] = autoOff_r;
      assign trip[b] = tripNow;
      assign processSpOut[b] = spOut_r;
      assign protTripped[b] = autoOff_r;
      assign dgOnReq[b] = fil && ((opDgOn && cmd.chan[2:1] == 2'(b)) ||
                                  (remoteDegasSel[b] && remRise[FC+1])); // RQ16
      assign dgOffReq[b] = (opDgOff && cmd.chan[2:1] == 2'(b)) ||
                           (remoteDegasSel[b] && remFall[FC+1]);
      assign boardOk[b] = wProc || wHyst || wCtrl || wRef || wMode || wProt ||
                          (hit && opDgOn && dgGrant[b]) || (hit && opDgOff && fil);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // degas admission across boards
  always_comb begin
    logic [1:0] cnt;
    logic glassAct;
    cnt = 2'h0;
    glassAct = 1'b0;
    dgGrant = '0;
    degas_nxt = '0;

    for (int k = 0; k < NBRD; k++) begin
      if (degas_r[k] && !dgOffReq[k] && power_nxt[2*k] && isFil[k] && !trip[k]) begin
        degas_nxt[k] = 1'b1;
        cnt = cnt + 2'h1;
        glassAct = glassAct || glassGauge[k];
      end
    end
    for (int k = 0; k < NBRD; k++) begin
      if (dgOnReq[k] && !degas_nxt[k] && power_nxt[2*k] && !trip[k] &&
          (cnt == 2'h0 || (cnt < ion_interlock_pkg::DEGAS_LIMIT && !glassAct && !glassGauge[k]))) begin
        dgGrant[k] = 1'b1; // RQ14
        degas_nxt[k] = 1'b1;
        cnt = cnt + 2'h1;
        glassAct = glassAct || glassGauge[k];
      end else if (dgOnReq[k] && degas_nxt[k]) begin
        dgGrant[k] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rangeExt_r <= 1'b0;
      cmdAck_r <= 1'b0;
      cmdNak_r <= 1'b0;
      power_r <= '0;
      degas_r <= '0;
    end else if (clkEn) begin
      if (rangeExtensionCommand) begin
        rangeExt_r <= 1'b1; // RQ6
      end
      cmdAck_r <= cmd.valid && cmdOk; // RQ1
      cmdNak_r <= cmd.valid && !cmdOk;
      power_r <= power_nxt;
      degas_r <= degas_nxt;
    end
  end
endmodule : ion_gauge_interlock

/* include/ion_interlock_pkg.sv */
// Purpose: shared types and constants of the filament gauge interlock
// Assumes: pressures are unsigned binary, one lsb = 1e-11 torr
// Notes: six channels on three boards, filament gauge on the first channel of a board
package ion_interlock_pkg;
  localparam int PW = 40;
  localparam int NCH = 6;
  localparam int NBRD = 3;
  localparam int DEGAS_MAX = 3;
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

  typedef logic [PW-1:0] press_type;

  // pressure figures in 1e-11 torr units
  localparam press_type P_5E_10 = 40'h32;
  localparam press_type P_1E_6 = 40'h186a0;
  localparam press_type P_1P5E_6 = 40'h249f0;
  localparam press_type P_1E_5 = 40'hf4240;
  localparam press_type P_5E_4 = 40'h2faf080;
  localparam press_type P_2E_3 = 40'hbebc200;
  localparam press_type P_5E_3 = 40'h1dcd6500;
  localparam press_type P_1E_2 = 40'h3b9aca00;
  localparam press_type P_2E_2 = 40'h77359400;
  localparam press_type P_9P5E_1 = 40'h161e70f600;

  localparam logic [3:0] HYST_MIN_NUM = 4'hb;
  localparam logic [3:0] HYST_MIN_DEN = 4'ha;
  localparam logic [8:0] FS_DIV = 9'h1f4;
  localparam logic [2:0] REF_NONE = 3'h7;
  localparam logic [1:0] DEGAS_LIMIT = 2'h3;

  typedef enum logic [2:0] {
    GAUGE_NONE = 3'h0,
    THERMAL_CONDUCTIVITY_GAUGE = 3'h1,
    CONVECTION_GAUGE = 3'h2,
    COLD_ION_GAUGE = 3'h3,
    FILAMENT_ION_GAUGE = 3'h4,
    DIAPHRAGM_GAUGE = 3'h5
  } gauge_type;

  typedef enum logic [1:0] {
    CTRL_OFF = 2'h0,
    CTRL_SAFE = 2'h1,
    CTRL_AUTO = 2'h3
  } ctrl_mode_type;

  typedef enum logic [3:0] {
    OP_PROCESS_THRESHOLD = 4'h0,
    OP_HYSTERESIS = 4'h1,
    OP_INTERLOCK_THRESHOLD = 4'h2,
    OP_REFERENCE_CHANNEL_SELECT = 4'h3,
    OP_MODE = 4'h4,
    OP_PROTECT = 4'h5,
    OP_POWER_ON = 4'h6,
    OP_POWER_OFF = 4'h7,
    OP_DEGAS_ON = 4'h8,
    OP_DEGAS_OFF = 4'h9
  } cmd_op_type;

  // chan[2:1] selects the board for board-level operations
  typedef struct packed {
    logic valid;
    cmd_op_type op;
    logic [2:0] chan;
    press_type value;
  } cmd_type;
endpackage : ion_interlock_pkg

/* bench/ion_gauge_interlock_chk.sv */
// Purpose: port-level checks of the filament gauge interlock
// Assumes: clkEn stays high while these are judged
// Notes: bound to every ion_gauge_interlock instance
`timescale 1ns/1ps
module ion_gauge_interlock_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire ion_interlock_pkg::gauge_type [ion_interlock_pkg::NCH-1:0] gaugeType,
  input wire logic [ion_interlock_pkg::NBRD-1:0] glassGauge,
  input wire ion_interlock_pkg::cmd_type cmd,
  input wire logic [ion_interlock_pkg::NCH-1:0] remotePullupEn,
  input wire logic cmdAck,
  input wire logic cmdNak,
  input wire logic [ion_interlock_pkg::NCH-1:0] sensorPower,
  input wire logic [ion_interlock_pkg::NCH-1:0] anodeHvEn,
  input wire logic [ion_interlock_pkg::NBRD-1:0] degasOn,
  input wire logic [ion_interlock_pkg::NBRD-1:0] protTripped
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [5:0] coldMask;
  logic [5:0] deadMask;
  logic badSp;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      coldMask[i] = gaugeType[i] == ion_interlock_pkg::COLD_ION_GAUGE;
      deadMask[i] = gaugeType[i] == ion_interlock_pkg::DIAPHRAGM_GAUGE;
    end
  end
  assign badSp = cmd.valid && clkEn && cmd.op == ion_interlock_pkg::OP_PROCESS_THRESHOLD
                 && (cmd.value < ion_interlock_pkg::P_5E_10 || cmd.value > ion_interlock_pkg::P_5E_3);
  ////////////////////////////////////////////////////////////////
  property p_pullup; remotePullupEn == 6'h3f; endproperty
  property p_anode; anodeHvEn == (sensorPower & coldMask); endproperty
  property p_dead; (deadMask != 6'h0) |=> ((sensorPower & $past(deadMask)) == 6'h0); endproperty
  property p_excl; !(cmdAck && cmdNak); endproperty
  property p_sprange; badSp |=> cmdNak && !cmdAck; endproperty
  property p_degmax; $countones(degasOn) <= ion_interlock_pkg::DEGAS_MAX; endproperty
  property p_glass; ((degasOn & glassGauge) != 3'h0) |-> $onehot(degasOn); endproperty
  property p_trip(b); $rose(protTripped[b]) |-> $past(sensorPower[2*b]) && !sensorPower[2*b]; endproperty
  property p_tripoff(b); protTripped[b] |-> !sensorPower[2*b]; endproperty
  property p_degpow(b); $rose(degasOn[b]) |-> sensorPower[2*b]; endproperty
  a_pullup: assert property (p_pullup) else $error("remote pull-up not enabled");
  a_anode: assert property (p_anode) else $error("anode enable differs from cold gauge power");
  a_dead: assert property (p_dead) else $error("diaphragm channel powered");
  a_excl: assert property (p_excl) else $error("ack and nak together");
  a_sprange: assert property (p_sprange) else $error("out of range threshold not refused");
  a_degmax: assert property (p_degmax) else $error("too many boards in degas");
  a_glass: assert property (p_glass) else $error("glass gauge degas not alone");
  for (genvar b = 0; b < 3; b++) begin : g_brd
    a_trip: assert property (p_trip(b)) else $error("trip without power cut");
    a_tripoff: assert property (p_tripoff(b)) else $error("powered while tripped");
    a_degpow: assert property (p_degpow(b)) else $error("degas without filament power");
  end
  c_ack: cover property (cmdAck);
  c_trip: cover property ($rose(protTripped[1]));
  c_degas: cover property (degasOn == 3'h7);
endmodule : ion_gauge_interlock_chk

bind ion_gauge_interlock ion_gauge_interlock_chk i_ion_gauge_interlock_chk (.clk_sys(clk_sys), .rst(rst),
  .clkEn(clkEn), .gaugeType(gaugeType), .glassGauge(glassGauge), .cmd(cmd), .remotePullupEn(remotePullupEn),
  .cmdAck(cmdAck), .cmdNak(cmdNak), .sensorPower(sensorPower), .anodeHvEn(anodeHvEn), .degasOn(degasOn),
  .protTripped(protTripped));

/* bench/remote_line_model.sv */
// Purpose: remote control lines, pulled to ground or released
// Assumes: a released line rests only on the device pull-up
// Notes: without pull-up a released line wanders every cycle
`timescale 1ns/1ps
module remote_line_model (
  input wire logic clk_sys,
  input wire logic [5:0] pullDown,
  input wire logic [5:0] pullupEn,
  output logic [5:0] remoteIn
);
  logic floatLevel_r = 1'b0;
  always_ff @(posedge clk_sys) floatLevel_r <= ~floatLevel_r;
  assign remoteIn = ~pullDown & (pullupEn | {6{floatLevel_r}});
endmodule : remote_line_model

/* bench/ion_gauge_setpoint_power_interlock_tb_top.sv */
// Purpose: self-checking bench of the filament gauge interlock
// Assumes: board gauges are filament, thermal, filament, convection, filament, diaphragm
// Notes: debounce shortened to 4 cycles
`timescale 1ns/1ps
module ion_gauge_setpoint_power_interlock_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [2:0] ty [6];
  ion_interlock_pkg::gauge_type [5:0] gt;
  ion_interlock_pkg::press_type [5:0] pr;
  ion_interlock_pkg::press_type [5:0] fs;
  ion_interlock_pkg::cmd_type cmd;
  logic [2:0] glass = 3'h0;
  logic [2:0] dsel = 3'h0;
  logic [5:0] pullDown = 6'h0;
  logic rangeExt = 1'b0;
  logic [5:0] pullupEn, remoteIn, pwr, hv;
  logic [2:0] degas, spOut, trip;
  logic ack, nak;
  int errors = 0;
  int num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gt[i] = ion_interlock_pkg::gauge_type'(ty[i]);
    end
  end
  ion_gauge_interlock #(.DEBOUNCE_CYCLES(4)) i_ion_gauge_interlock (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
    .gaugeType(gt), .pressure(pr), .fullScale(fs), .glassGauge(glass), .remoteDegasSel(dsel), .remoteIn(remoteIn),
    .cmd(cmd), .rangeExtensionCommand(rangeExt), .remotePullupEn(pullupEn), .cmdAck(ack), .cmdNak(nak),
    .sensorPower(pwr), .anodeHvEn(hv), .degasOn(degas), .processSpOut(spOut), .protTripped(trip));
  remote_line_model i_remote_line_model (.clk_sys(clk_sys), .pullDown(pullDown), .pullupEn(pullupEn),
    .remoteIn(remoteIn));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic cm(input logic [3:0] op, input logic [2:0] ch, input logic [39:0] v, input logic ok);
    @(posedge clk_sys);
    cmd <= '{1'b1, ion_interlock_pkg::cmd_op_type'(op), ch, v};
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
    #1;
    chk("answer", {ack, nak}, {ok, ~ok});
  endtask : cm
  task automatic ps(input int ch, input logic [39:0] v);
    @(posedge clk_sys);
    pr[ch] <= v;
    tick(3);
  endtask : ps
  task automatic rl(input int ch, input logic lvl, input int n);
    @(posedge clk_sys);
    pullDown[ch] <= ~lvl;
    tick(n);
  endtask : rl
  ////////////////////////////////////////////////////////////////
  task automatic t_setpoint;
    cm(4'h0, 3'h0, 40'h31, 1'b0);
    cm(4'h0, 3'h0, ion_interlock_pkg::P_5E_3 + 40'h1, 1'b0);
    cm(4'h0, 3'h0, ion_interlock_pkg::P_5E_10, 1'b1);
    cm(4'h0, 3'h0, ion_interlock_pkg::P_5E_3, 1'b1);
    cm(4'h0, 3'h0, 40'h3e8, 1'b1);
    ps(0, 40'h3e7);
    chk("sp below", spOut[0], 1'b1);
    ps(0, 40'h5dc);
    chk("sp held", spOut[0], 1'b1);
    ps(0, 40'h5dd);
    chk("sp clear", spOut[0], 1'b0);
    ps(0, 40'h3e8);
    chk("sp at thr", spOut[0], 1'b0);
    cm(4'h1, 3'h0, 40'h44b, 1'b0);
    cm(4'h1, 3'h0, 40'h44c, 1'b1);
    ps(0, 40'h3e7);
    ps(0, 40'h44d);
    chk("sp new hyst", spOut[0], 1'b0);
  endtask : t_setpoint
  task automatic t_interlock;
    cm(4'h4, 3'h0, 40'h3, 1'b0);
    cm(4'h2, 3'h0, ion_interlock_pkg::P_5E_3, 1'b0);
    cm(4'h3, 3'h0, 40'h0, 1'b0);
    cm(4'h3, 3'h0, 40'h1, 1'b1);
    cm(4'h4, 3'h0, 40'h2, 1'b0);
    cm(4'h4, 3'h0, 40'h3, 1'b1);
    ps(1, ion_interlock_pkg::P_5E_3 - 40'h1);
    chk("auto on", pwr[0], 1'b1);
    ps(1, ion_interlock_pkg::P_5E_3);
    chk("auto off", pwr[0], 1'b0);
    cm(4'h2, 3'h0, ion_interlock_pkg::P_5E_4 - 40'h1, 1'b0);
    cm(4'h2, 3'h0, ion_interlock_pkg::P_5E_4, 1'b1);
    cm(4'h2, 3'h0, ion_interlock_pkg::P_1E_2 + 40'h1, 1'b0);
    @(posedge clk_sys);
    rangeExt <= 1'b1;
    @(posedge clk_sys);
    rangeExt <= 1'b0;
    cm(4'h2, 3'h0, ion_interlock_pkg::P_1E_2 + 40'h1, 1'b1);
    cm(4'h2, 3'h0, ion_interlock_pkg::P_9P5E_1 + 40'h1, 1'b0);
    cm(4'h2, 3'h0, ion_interlock_pkg::P_5E_3, 1'b1);
    ps(1, 40'h0);
    cm(4'h4, 3'h0, 40'h1, 1'b1);
    ps(1, ion_interlock_pkg::P_5E_3);
    chk("safe off", pwr[0], 1'b0);
    ps(1, 40'h0);
    chk("safe stays off", pwr[0], 1'b0);
    cm(4'h6, 3'h0, 40'h0, 1'b1);
    chk("safe manual on", pwr[0], 1'b1);
    cm(4'h4, 3'h0, 40'h0, 1'b1);
    ps(1, ion_interlock_pkg::P_5E_3);
    chk("off ignores ref", pwr[0], 1'b1);
    cm(4'h7, 3'h0, 40'h0, 1'b1);
    chk("off manual", pwr[0], 1'b0);
    cm(4'h3, 3'h2, 40'h3, 1'b1);
    cm(4'h2, 3'h2, ion_interlock_pkg::P_2E_3 - 40'h1, 1'b0);
    cm(4'h2, 3'h2, ion_interlock_pkg::P_2E_3, 1'b1);
    cm(4'h3, 3'h4, 40'h5, 1'b1);
    cm(4'h2, 3'h4, 40'h17d783ff, 1'b0);
    cm(4'h2, 3'h4, 40'h17d78400, 1'b1);
  endtask : t_interlock
  task automatic t_protect;
    cm(4'h5, 3'h2, ion_interlock_pkg::P_1E_2 + 40'h1, 1'b0);
    cm(4'h5, 3'h2, ion_interlock_pkg::P_1E_5 - 40'h1, 1'b0);
    cm(4'h4, 3'h2, 40'h3, 1'b1);
    ps(2, ion_interlock_pkg::P_5E_3);
    chk("below trip", pwr[2], 1'b1);
    ps(2, ion_interlock_pkg::P_5E_3 + 40'h1);
    chk("tripped", {pwr[2], trip[1]}, 2'h1);
    ps(2, 40'h0);
    chk("auto held off", pwr[2], 1'b0);
    cm(4'h6, 3'h2, 40'h0, 1'b1);
    chk("manual clears", {pwr[2], trip[1]}, 2'h2);
    cm(4'h4, 3'h2, 40'h0, 1'b1);
  endtask : t_protect
  task automatic t_types;
    for (int t = 1; t < 6; t++) begin
      @(posedge clk_sys);
      ty[3] <= 3'(t);
      cm(4'h6, 3'h3, 40'h0, t < 5);
      chk("type power", pwr[3], t < 5);
      chk("anode", hv[3], t == 3);
      cm(4'h7, 3'h3, 40'h0, t < 5);
    end
  endtask : t_types
  task automatic t_degas;
    cm(4'h6, 3'h0, 40'h0, 1'b1);
    cm(4'h6, 3'h4, 40'h0, 1'b1);
    for (int b = 0; b < 3; b++) cm(4'h8, 3'(2 * b), 40'h0, 1'b1);
    chk("degas three", degas, 3'h7);
    for (int b = 0; b < 3; b++) cm(4'h9, 3'(2 * b), 40'h0, 1'b1);
    @(posedge clk_sys);
    glass <= 3'h1;
    cm(4'h8, 3'h0, 40'h0, 1'b1);
    cm(4'h8, 3'h2, 40'h0, 1'b0);
    cm(4'h9, 3'h0, 40'h0, 1'b1);
    @(posedge clk_sys);
    glass <= 3'h0;
    cm(4'h7, 3'h4, 40'h0, 1'b1);
    cm(4'h8, 3'h4, 40'h0, 1'b0);
  endtask : t_degas
  task automatic t_remote;
    cm(4'h6, 3'h1, 40'h0, 1'b1);
    rl(1, 1'b0, 2);
    rl(1, 1'b1, 12);
    chk("glitch", pwr[1], 1'b1);
    rl(1, 1'b0, 12);
    chk("fall off", pwr[1], 1'b0);
    cm(4'h6, 3'h1, 40'h0, 1'b1);
    tick(12);
    chk("level ignored", pwr[1], 1'b1);
    cm(4'h7, 3'h1, 40'h0, 1'b1);
    rl(1, 1'b1, 12);
    chk("rise on", pwr[1], 1'b1);
    @(posedge clk_sys);
    dsel <= 3'h1;
    cm(4'h8, 3'h0, 40'h0, 1'b1);
    rl(1, 1'b0, 12);
    chk("degas fall", {degas[0], pwr[1]}, 2'h1);
    rl(1, 1'b1, 12);
    chk("degas rise", degas[0], 1'b1);
  endtask : t_remote
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #500us;
    errors++;
    give_verdict();
  end
  initial begin
    ty = '{3'h4, 3'h1, 3'h4, 3'h2, 3'h4, 3'h5};
    pr = '0;
    fs = '0;
    fs[5] = 40'h2e90edd000;
    cmd = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_setpoint();
    t_interlock();
    t_protect();
    t_types();
    t_degas();
    t_remote();
    give_verdict();
  end
endmodule : ion_gauge_setpoint_power_interlock_tb_top
